// ===== rtl/timer16_pkg.sv
// Constants shared by the 16-bit timer access block
package timer16_pkg;
  // I/O location indices on the 8-bit register port
  localparam logic [3:0] ADDR_COUNTER_LOW   = 4'h0;
  localparam logic [3:0] ADDR_COUNTER_HIGH  = 4'h1;
  localparam logic [3:0] ADDR_COMPARE_A_LOW = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_A_HI  = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_B_LOW = 4'h4;
  localparam logic [3:0] ADDR_COMPARE_B_HI  = 4'h5;
  localparam logic [3:0] ADDR_CAPTURE_LOW   = 4'h6;
  localparam logic [3:0] ADDR_CAPTURE_HIGH  = 4'h7;
  localparam logic [3:0] ADDR_CONTROL_A     = 4'h8;
  localparam logic [3:0] ADDR_CONTROL_B     = 4'h9;
  localparam logic [3:0] ADDR_FLAGS         = 4'hA;
  localparam logic [3:0] ADDR_MASK          = 4'hB;
  localparam logic [3:0] ADDR_SPECIAL_IO    = 4'hC;
  // Control A fields
  localparam int CTRL_A_WGM_LSB   = 0;
  localparam int CTRL_A_FORCE_B   = 2;
  localparam int CTRL_A_FORCE_A   = 3;
  localparam int CTRL_A_COM_B_LSB = 4;
  localparam int CTRL_A_COM_A_LSB = 6;
  localparam logic [7:0] CTRL_A_STORE_MASK = 8'hF3;
  // Control B fields
  localparam int CTRL_B_CS_LSB    = 0;
  localparam int CTRL_B_WGM_LSB   = 3;
  localparam int CTRL_B_EDGE      = 6;
  localparam int CTRL_B_NOISE     = 7;
  localparam logic [7:0] CTRL_B_STORE_MASK = 8'hDF;
  // Flag and mask bit positions
  localparam int FLAG_OVERFLOW  = 2;
  localparam int FLAG_COMPARE_B = 3;
  localparam int FLAG_COMPARE_A = 4;
  localparam int FLAG_CAPTURE   = 5;
  localparam logic [7:0] FLAG_MASK = 8'h3C;
  // Special function register
  localparam int SFIO_PRESCALER_RESET = 0;
  localparam logic [7:0] SFIO_STORE_MASK = 8'hEC;
  // Reset values
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Counter limits
  localparam logic [15:0] LIMIT_BOTTOM = 16'h0000;
  localparam logic [15:0] LIMIT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT     = 16'h00FF;
  localparam logic [15:0] TOP_9BIT     = 16'h01FF;
  localparam logic [15:0] TOP_10BIT    = 16'h03FF;
  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIRECT   = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESCALE_DIV8    = 8;
  localparam int PRESCALE_DIV64   = 64;
  localparam int PRESCALE_DIV256  = 256;
  localparam int PRESCALE_DIV1024 = 1024;
  localparam int PRESCALER_BITS   = 10;
  // Compare output actions
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
  // Capture noise filter length in clock cycles
  localparam int NOISE_SAMPLES = 4;
endpackage

// ===== rtl/timer16_access.sv
// 16-bit timer front end: shared prescaler, byte access path, limits, flags
// Functional notes
// - Writing one to prescaler reset restarts shared prescaler; bit self-clears; zero ignored.
// - Prescaler reset disturbs tick timing of both timers sharing it.
// - Prescaler reset bit always reads as zero.
// - Counter, compares and capture are 16 bits, reached by two byte operations.
// - One shared 8-bit high-byte holding register serves all 16-bit registers.
// - Low-byte write loads holding byte and written byte into target together.
// - Counter or capture low-byte read copies target high byte into holding register same cycle.
// - Compare register reads return high byte directly, holding register untouched.
// - Control registers are single bytes, accessed directly without holding register.
// - Clock select picks prescaled or external tick; stop code halts counter.
// - Compare registers are matched on each timer tick; match sets flag, drives output.
// - Capture edge from pin or comparator stores counter; optional noise filter.
// - Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture by mode.
// - Compare A as PWM top gives no PWM output; its top is double buffered.
// - Bottom signalled at 0x0000, maximum signalled at 0xFFFF.
// - Overflow, compare A, compare B, capture flags, each enabled by mask.
// - Control A holds force bits and mode bits 0-1; B holds bits 2-3.
// - Internal tick is the I/O clock or taps dividing by 8, 64, 256, 1024.
// - External code 7 counts rising edges, code 6 falling edges.
// - Processor counter write wins over clear or count in the same cycle.
`timescale 1ns/1ps
module timer16_access
  import timer16_pkg::*;
#(
  parameter int PRESCALER_WIDTH = PRESCALER_BITS,
  parameter int NOISE_LENGTH    = NOISE_SAMPLES
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic [3:0] IO_ADDR,
  input  wire logic       IO_WRITE,
  input  wire logic       IO_READ,
  input  wire logic [7:0] IO_WDATA,
  output logic      [7:0] IO_RDATA,
  input  wire logic       EXTERNAL_COUNT_PIN,
  input  wire logic       CAPTURE_PIN,
  input  wire logic       COMPARATOR_OUT,
  input  wire logic       CAPTURE_FROM_COMPARATOR,
  output logic            COMPARE_A_OUTPUT,
  output logic            COMPARE_B_OUTPUT,
  output logic            BOTTOM_REACHED,
  output logic            MAX_REACHED,
  output logic      [3:0] PRESCALE_TAPS,
  output logic      [3:0] IRQ_REQUEST
);

  initial begin
    if (PRESCALER_WIDTH < $clog2(PRESCALE_DIV1024)) begin
      $error("prescaler too narrow for the largest tap");
    end
    if (NOISE_LENGTH < 2 || NOISE_LENGTH > 15) begin
      $error("noise filter length out of range");
    end
  end

  typedef struct packed {
    logic [PRESCALER_WIDTH-1:0] prescaler;
    logic [7:0]  hold;
    logic [15:0] counter;
    logic [15:0] compare_a_buf;
    logic [15:0] compare_a;
    logic [15:0] compare_b_buf;
    logic [15:0] compare_b;
    logic [15:0] capture;
    logic [7:0]  control_a;
    logic [7:0]  control_b;
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [7:0]  special_io;
    logic [7:0]  rdata;
    logic [2:0]  ext_sync;
    logic        ext_level;
    logic [2:0]  cap_sync;
    logic        cap_level;
    logic [3:0]  cap_stable;
    logic        out_a;
    logic        out_b;
    logic        bottom;
    logic        max;
    logic [3:0]  irq;
  } state_s;

  state_s state;
  state_s next_state;

  function automatic logic [3:0] mode_of(input logic [7:0] ca, input logic [7:0] cb);
    mode_of = {cb[CTRL_B_WGM_LSB+1], cb[CTRL_B_WGM_LSB], ca[CTRL_A_WGM_LSB+1], ca[CTRL_A_WGM_LSB]};
  endfunction

  // Modes whose compare registers reload only at top
  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = !(mode == 4'h0 || mode == 4'h4 || mode == 4'hC);
  endfunction

  function automatic logic top_is_compare_a(input logic [3:0] mode);
    top_is_compare_a = (mode == 4'h4 || mode == 4'h9 || mode == 4'hB || mode == 4'hF);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cmp_a,
                                         input logic [15:0] cap);
    case (mode)
      4'h1, 4'h5: top_of = TOP_8BIT;
      4'h2, 4'h6: top_of = TOP_9BIT;
      4'h3, 4'h7: top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
      default: top_of = LIMIT_MAX;
    endcase
  endfunction

  function automatic logic apply_action(input logic [1:0] com, input logic cur);
    case (com)
      COM_TOGGLE: apply_action = !cur;
      COM_CLEAR:  apply_action = 1'b0;
      COM_SET:    apply_action = 1'b1;
      default:    apply_action = cur;
    endcase
  endfunction

  localparam int TAP_DIV [4] = '{PRESCALE_DIV8, PRESCALE_DIV64, PRESCALE_DIV256,
                                 PRESCALE_DIV1024};

  logic [3:0]  taps;
  logic [3:0]  mode;
  logic [2:0]  clock_select;
  logic [15:0] top;
  logic        ext_rise;
  logic        ext_fall;
  logic        timer_tick;
  logic        cap_edge;
  logic        prescaler_restart;
  logic        wr_counter_low;

  // Tap fires on the last count of its period, so all taps share one divider
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_tap
      assign taps[g] = &state.prescaler[$clog2(TAP_DIV[g])-1:0];
    end
  endgenerate

  assign mode              = mode_of(state.control_a, state.control_b);
  assign clock_select      = state.control_b[CTRL_B_CS_LSB +: 3];
  assign top               = top_of(mode, state.compare_a, state.capture);
  assign prescaler_restart = IO_WRITE && IO_ADDR == ADDR_SPECIAL_IO
                             && IO_WDATA[SFIO_PRESCALER_RESET];
  assign wr_counter_low    = IO_WRITE && IO_ADDR == ADDR_COUNTER_LOW;

  // Edges come from the filtered level; the first sync stage feeds only the second
  always_comb begin
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    if (state.ext_sync[1] == state.ext_sync[2] && state.ext_sync[2] != state.ext_level) begin
      ext_rise = state.ext_sync[2];
      ext_fall = !state.ext_sync[2];
    end
  end

  always_comb begin
    case (clock_select)
      CS_STOP:     timer_tick = 1'b0;
      CS_DIRECT:   timer_tick = 1'b1;
      CS_DIV8:     timer_tick = taps[0];
      CS_DIV64:    timer_tick = taps[1];
      CS_DIV256:   timer_tick = taps[2];
      CS_DIV1024:  timer_tick = taps[3];
      CS_EXT_FALL: timer_tick = ext_fall;
      CS_EXT_RISE: timer_tick = ext_rise;
      default:     timer_tick = 1'b0;
    endcase
  end

  // Noise filter trades NOISE_LENGTH - 1 cycles of delay for spike rejection
  logic cap_candidate;
  logic cap_accept;
  assign cap_candidate = state.cap_sync[1] == state.cap_sync[2]
                         && state.cap_sync[2] != state.cap_level;
  assign cap_accept    = cap_candidate && (!state.control_b[CTRL_B_NOISE]
                         || state.cap_stable == 4'(NOISE_LENGTH - 1));
  assign cap_edge      = cap_accept && (state.cap_sync[2] == state.control_b[CTRL_B_EDGE]);

  always_comb begin
    logic [15:0] counted;
    logic        at_top;
    logic        match_a;
    logic        match_b;
    logic [7:0]  set_flags;
    counted   = state.counter;
    at_top    = state.counter == top;
    match_a   = timer_tick && state.counter == state.compare_a;
    match_b   = timer_tick && state.counter == state.compare_b;
    set_flags = RESET_BYTE;
    next_state = state;
    next_state.rdata = RESET_BYTE;

    // Shared divider, restarted for every timer that taps it
    next_state.prescaler = prescaler_restart ? '0 : state.prescaler + 1'b1;

    next_state.ext_sync  = {state.ext_sync[1:0], EXTERNAL_COUNT_PIN};
    if (state.ext_sync[1] == state.ext_sync[2]) begin
      next_state.ext_level = state.ext_sync[2];
    end
    next_state.cap_sync = {state.cap_sync[1:0],
                           CAPTURE_FROM_COMPARATOR ? COMPARATOR_OUT : CAPTURE_PIN};
    if (!cap_candidate || cap_accept) begin
      next_state.cap_stable = 4'h0;
    end else begin
      next_state.cap_stable = state.cap_stable + 4'h1;
    end
    if (cap_accept) begin
      next_state.cap_level = state.cap_sync[2];
    end

    // Counting, overflow at top in PWM modes, else at MAX
    if (timer_tick) begin
      counted = at_top ? LIMIT_BOTTOM : state.counter + 16'h0001;
      if (is_pwm(mode) ? at_top : state.counter == LIMIT_MAX) begin
        set_flags[FLAG_OVERFLOW] = 1'b1;
      end
    end
    if (match_a) begin
      set_flags[FLAG_COMPARE_A] = 1'b1;
    end
    if (match_b) begin
      set_flags[FLAG_COMPARE_B] = 1'b1;
    end

    // Compare A as PWM top cannot drive a waveform
    if (match_a && !(is_pwm(mode) && top_is_compare_a(mode))) begin
      next_state.out_a = apply_action(state.control_a[CTRL_A_COM_A_LSB +: 2], state.out_a);
    end
    if (match_b) begin
      next_state.out_b = apply_action(state.control_a[CTRL_A_COM_B_LSB +: 2], state.out_b);
    end

    // Double buffering: PWM modes reload at top, others follow at once
    if (!is_pwm(mode) || (timer_tick && at_top)) begin
      next_state.compare_a = state.compare_a_buf;
      next_state.compare_b = state.compare_b_buf;
    end

    if (cap_edge) begin
      next_state.capture = state.counter;
      set_flags[FLAG_CAPTURE] = 1'b1;
    end

    // Reads
    if (IO_READ) begin
      case (IO_ADDR)
        ADDR_COUNTER_LOW: begin
          next_state.rdata = state.counter[7:0];
          next_state.hold  = state.counter[15:8];
        end
        ADDR_CAPTURE_LOW: begin
          next_state.rdata = state.capture[7:0];
          next_state.hold  = state.capture[15:8];
        end
        ADDR_COUNTER_HIGH, ADDR_CAPTURE_HIGH: next_state.rdata = state.hold;
        ADDR_COMPARE_A_LOW: next_state.rdata = state.compare_a_buf[7:0];
        ADDR_COMPARE_A_HI:  next_state.rdata = state.compare_a_buf[15:8];
        ADDR_COMPARE_B_LOW: next_state.rdata = state.compare_b_buf[7:0];
        ADDR_COMPARE_B_HI:  next_state.rdata = state.compare_b_buf[15:8];
        ADDR_CONTROL_A:     next_state.rdata = state.control_a;
        ADDR_CONTROL_B:     next_state.rdata = state.control_b;
        ADDR_FLAGS:         next_state.rdata = state.flags;
        ADDR_MASK:          next_state.rdata = state.mask;
        ADDR_SPECIAL_IO:    next_state.rdata = state.special_io;
        default:            next_state.rdata = RESET_BYTE;
      endcase
    end

    // Writes; any high byte lands in the shared holding register
    next_state.counter = counted;
    next_state.flags   = state.flags | set_flags;
    if (IO_WRITE) begin
      case (IO_ADDR)
        ADDR_COUNTER_HIGH, ADDR_COMPARE_A_HI, ADDR_COMPARE_B_HI, ADDR_CAPTURE_HIGH:
          next_state.hold = IO_WDATA;
        ADDR_COUNTER_LOW:   next_state.counter = {state.hold, IO_WDATA};
        ADDR_COMPARE_A_LOW: next_state.compare_a_buf = {state.hold, IO_WDATA};
        ADDR_COMPARE_B_LOW: next_state.compare_b_buf = {state.hold, IO_WDATA};
        ADDR_CAPTURE_LOW:   next_state.capture = {state.hold, IO_WDATA};
        ADDR_CONTROL_A: begin
          next_state.control_a = IO_WDATA & CTRL_A_STORE_MASK;
          // Force bits act once outside PWM modes and never store; no flag is raised
          if (IO_WDATA[CTRL_A_FORCE_A] && !is_pwm(mode)) begin
            next_state.out_a = apply_action(state.control_a[CTRL_A_COM_A_LSB +: 2], state.out_a);
          end
          if (IO_WDATA[CTRL_A_FORCE_B] && !is_pwm(mode)) begin
            next_state.out_b = apply_action(state.control_a[CTRL_A_COM_B_LSB +: 2], state.out_b);
          end
        end
        ADDR_CONTROL_B: next_state.control_b = IO_WDATA & CTRL_B_STORE_MASK;
        // Write one clears; a flag set this cycle survives
        ADDR_FLAGS:     next_state.flags = (state.flags & ~IO_WDATA & FLAG_MASK) | set_flags;
        ADDR_MASK:      next_state.mask = IO_WDATA & FLAG_MASK;
        ADDR_SPECIAL_IO: next_state.special_io = IO_WDATA & SFIO_STORE_MASK;
        default: ;
      endcase
    end

    next_state.bottom = next_state.counter == LIMIT_BOTTOM;
    next_state.max    = next_state.counter == LIMIT_MAX;
    next_state.irq    = {next_state.flags[FLAG_CAPTURE], next_state.flags[FLAG_COMPARE_A],
                         next_state.flags[FLAG_COMPARE_B], next_state.flags[FLAG_OVERFLOW]}
                        & {next_state.mask[FLAG_CAPTURE], next_state.mask[FLAG_COMPARE_A],
                           next_state.mask[FLAG_COMPARE_B], next_state.mask[FLAG_OVERFLOW]};
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state        <= '0;
      state.bottom <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign IO_RDATA         = state.rdata;
  assign COMPARE_A_OUTPUT = state.out_a;
  assign COMPARE_B_OUTPUT = state.out_b;
  assign BOTTOM_REACHED   = state.bottom;
  assign MAX_REACHED      = state.max;
  assign PRESCALE_TAPS    = taps;
  assign IRQ_REQUEST      = state.irq;

  default clocking cb_core @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  prescaler_restart_a: assert property (prescaler_restart |=> state.prescaler == '0
    ##[7:7] taps[0]) else $error("prescaler restart did not give a full period");
  prescaler_read_zero_a: assert property (IO_READ && IO_ADDR == ADDR_SPECIAL_IO
    |=> !IO_RDATA[SFIO_PRESCALER_RESET]) else $error("prescaler reset bit read as one");
  low_write_load_a: assert property (wr_counter_low
    |=> state.counter == {$past(state.hold), $past(IO_WDATA)})
    else $error("low byte write did not load full counter");
  low_read_hold_a: assert property (IO_READ && IO_ADDR == ADDR_COUNTER_LOW
    |=> state.hold == $past(state.counter[15:8]) && IO_RDATA == $past(state.counter[7:0]))
    else $error("low byte read did not stage high byte");
  compare_read_direct_a: assert property (IO_READ && IO_ADDR == ADDR_COMPARE_A_HI
    && !IO_WRITE |=> $stable(state.hold) && IO_RDATA == $past(state.compare_a_buf[15:8]))
    else $error("compare high read used holding register");
  stopped_counter_a: assert property (clock_select == CS_STOP && !wr_counter_low
    |=> $stable(state.counter)) else $error("counter moved with no clock source");
  compare_flag_a: assert property (timer_tick && state.counter == state.compare_a
    |=> state.flags[FLAG_COMPARE_A]) else $error("compare match did not set flag");
  capture_store_a: assert property (cap_edge && !IO_WRITE
    |=> state.capture == $past(state.counter) && state.flags[FLAG_CAPTURE])
    else $error("capture edge did not store counter");
  fixed_top_a: assert property (mode == 4'h5 && state.counter == TOP_8BIT && timer_tick
    && !wr_counter_low |=> state.counter == LIMIT_BOTTOM)
    else $error("8-bit top did not wrap");
  limit_signal_a: assert property (BOTTOM_REACHED == (state.counter == LIMIT_BOTTOM)
    && MAX_REACHED == (state.counter == LIMIT_MAX)) else $error("limit signal wrong");
  flag_set_wins_a: assert property (cap_edge && IO_WRITE && IO_ADDR == ADDR_FLAGS
    |=> state.flags[FLAG_CAPTURE]) else $error("flag clear lost a new event");
  external_rise_a: assert property (clock_select == CS_EXT_RISE && ext_fall
    && !wr_counter_low |=> $stable(state.counter)) else $error("falling edge counted");

  capture_event_c:   cover property (cap_edge ##1 IO_READ && IO_ADDR == ADDR_CAPTURE_LOW);
  prescaler_reset_c: cover property (prescaler_restart ##1 taps[3] == 1'b0);
  overflow_c:        cover property (timer_tick && state.counter == LIMIT_MAX);
  compare_out_c:     cover property (timer_tick && state.counter == state.compare_b);

endmodule

// ===== verification/cpu_bus_model.sv
// Processor-side model of the byte-wide timer register port
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic       clk,
  output logic      [3:0] addr,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    addr  = 4'hF;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end
  // Released lines show the inverse, so a stale value is never mistaken for live data
  task automatic release_bus();
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = ~addr;
    wdata = ~wdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    release_bus();
  endtask
  // Data is registered at the taking edge, so it is sampled half a cycle later
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clk);
    d = rdata;
    release_bus();
  endtask
  task automatic wr16(input logic [3:0] lo, input logic [15:0] val);
    wr(lo + 4'h1, val[15:8]);
    wr(lo, val[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] val);
    rd(lo, val[7:0]);
    rd(lo + 4'h1, val[15:8]);
  endtask
endmodule

// ===== verification/sixteen_bit_timer_access_test.sv
// Self-checking bench for the 16-bit timer access block
`timescale 1ns/1ps
module sixteen_bit_timer_access_test
  import timer16_pkg::*;
;
  logic        clk;
  logic        reset;
  logic [3:0]  addr;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        ext_pin;
  logic        cap_pin;
  logic        comp_out;
  logic        cap_sel;
  logic [3:0]  taps;
  logic [3:0]  irq;
  logic        bottom;
  logic        max_hit;
  logic        out_a;
  logic        out_b;
  logic [5:0]  watch;
  logic [15:0] v;
  int          fails;
  int          comparisons;
  int          first [4];
  int          divs [4];
  assign watch = {bottom, max_hit, irq};
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  cpu_bus_model cpu (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
                     .wdata(wdata), .rdata(rdata));
  timer16_access DUT (.CORE_CLK(clk), .RESET(reset), .IO_ADDR(addr), .IO_WRITE(wr_en),
    .IO_READ(rd_en), .IO_WDATA(wdata), .IO_RDATA(rdata), .EXTERNAL_COUNT_PIN(ext_pin),
    .CAPTURE_PIN(cap_pin), .COMPARATOR_OUT(comp_out), .CAPTURE_FROM_COMPARATOR(cap_sel),
    .COMPARE_A_OUTPUT(out_a), .COMPARE_B_OUTPUT(out_b), .BOTTOM_REACHED(bottom),
    .MAX_REACHED(max_hit), .PRESCALE_TAPS(taps), .IRQ_REQUEST(irq));
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic rc16(input logic [3:0] a, input logic [15:0] exp);
    cpu.rd16(a, v);
    chk(v, exp);
  endtask
  // Bounded wait on one watched event line
  task automatic wait_event(input int i);
    int n;
    n = 0;
    while (watch[i] !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (watch[i] !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: no event on watch bit %0d", $time, i);
      results();
    end
  endtask
  initial begin
    reset = 1'b1;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    comp_out = 1'b0;
    cap_sel = 1'b0;
    fails = 0;
    comparisons = 0;
    divs = '{PRESCALE_DIV8, PRESCALE_DIV64, PRESCALE_DIV256, PRESCALE_DIV1024};
    repeat (8) @(negedge clk);
    reset = 1'b0;
    chk({15'h0000, bottom}, 16'h0001);
    rc(ADDR_FLAGS, 8'h00);
    rc(4'hD, 8'h00);
    cpu.wr(ADDR_CONTROL_A, 8'hFF);
    rc(ADDR_CONTROL_A, 8'hF3);
    cpu.wr(ADDR_CONTROL_B, 8'hF8);
    rc(ADDR_CONTROL_B, 8'hD8);
    cpu.wr(ADDR_CONTROL_A, 8'h00);
    cpu.wr(ADDR_CONTROL_B, 8'h00);
    cpu.wr16(ADDR_COUNTER_LOW, 16'h01FF);
    rc16(ADDR_COUNTER_LOW, 16'h01FF);
    cpu.wr16(ADDR_COMPARE_A_LOW, 16'h0005);
    cpu.wr(ADDR_COMPARE_B_LOW, 8'h06);
    cpu.rd(ADDR_COUNTER_LOW, v[7:0]);
    rc(ADDR_COMPARE_A_HI, 8'h00);
    rc(ADDR_COUNTER_HIGH, 8'h01);
    rc(ADDR_COMPARE_B_LOW, 8'h06);
    cpu.wr(ADDR_CAPTURE_HIGH, 8'h77);
    cpu.wr(ADDR_COUNTER_LOW, 8'h10);
    rc16(ADDR_COUNTER_LOW, 16'h7710);
    cpu.wr(ADDR_SPECIAL_IO, 8'hED);
    first = '{default: 0};
    for (int n = 1; n <= 1100; n++) begin
      for (int k = 0; k < 4; k++) begin
        if (taps[k] === 1'b1 && first[k] == 0) first[k] = n;
      end
      @(negedge clk);
    end
    for (int k = 0; k < 4; k++) chk(16'(first[k]), 16'(divs[k]));
    rc(ADDR_SPECIAL_IO, 8'hEC);
    rc16(ADDR_COUNTER_LOW, 16'h7710);
    cpu.wr(ADDR_MASK, 8'h3C);
    rc(ADDR_MASK, 8'h3C);
    for (int s = 0; s < 2; s++) begin
      // Second pass runs the capture through the noise filter
      cpu.wr(ADDR_CONTROL_B, {s[0], 7'h40});
      cpu.wr16(ADDR_COUNTER_LOW, 16'h1234 + 16'(s));
      cap_sel = s[0];
      cap_pin = (s == 0);
      comp_out = (s == 1);
      wait_event(3);
      rc16(ADDR_CAPTURE_LOW, 16'h1234 + 16'(s));
      cpu.wr(ADDR_FLAGS, 8'h20);
      rc(ADDR_FLAGS, 8'h00);
      cap_pin = 1'b0;
      comp_out = 1'b0;
    end
    // Flag clear lands on the very edge that captures
    cpu.wr(ADDR_CONTROL_B, 8'h40);
    cap_sel = 1'b0;
    repeat (4) @(negedge clk);
    cap_pin = 1'b1;
    repeat (2) @(negedge clk);
    cpu.wr(ADDR_FLAGS, 8'h20);
    rc(ADDR_FLAGS, 8'h20);
    cap_pin = 1'b0;
    cpu.wr(ADDR_FLAGS, 8'h20);
    cpu.wr(ADDR_CONTROL_A, 8'h70);
    cpu.wr16(ADDR_COUNTER_LOW, 16'hFFF0);
    cpu.wr(ADDR_CONTROL_B, {5'h00, CS_DIRECT});
    wait_event(4);
    wait_event(5);
    wait_event(2);
    wait_event(1);
    wait_event(0);
    rc(ADDR_FLAGS, 8'h1C);
    chk({14'h0000, out_a, out_b}, 16'h0003);
    cpu.wr(ADDR_CONTROL_A, 8'h78);
    chk({14'h0000, out_a, out_b}, 16'h0001);
    rc(ADDR_CONTROL_A, 8'h70);
    // Counter still running: a lost write would leave it near 0x0013
    cpu.wr16(ADDR_COUNTER_LOW, 16'h0100);
    cpu.wr(ADDR_CONTROL_B, 8'h00);
    cpu.rd16(ADDR_COUNTER_LOW, v);
    chk({15'h0000, (v - 16'h0100) < 16'h0008}, 16'h0001);
    for (int c = 0; c < 2; c++) begin
      cpu.wr16(ADDR_COUNTER_LOW, 16'h0000);
      cpu.wr(ADDR_CONTROL_B, {5'h00, (c == 0) ? CS_EXT_RISE : CS_EXT_FALL});
      // Four rising and three falling edges
      for (int p = 0; p < 7; p++) begin
        ext_pin = ~ext_pin;
        repeat (4) @(negedge clk);
      end
      cpu.wr(ADDR_CONTROL_B, 8'h00);
      ext_pin = 1'b0;
      repeat (4) @(negedge clk);
      rc16(ADDR_COUNTER_LOW, (c == 0) ? 16'h0004 : 16'h0003);
    end
    // Fixed 8-bit top: bottom within a few ticks, not after a full wrap
    cpu.wr(ADDR_FLAGS, 8'h3C);
    cpu.wr16(ADDR_COUNTER_LOW, 16'h00F8);
    cpu.wr(ADDR_CONTROL_A, 8'h01);
    cpu.wr(ADDR_CONTROL_B, 8'h09);
    wait_event(5);
    rc(ADDR_FLAGS, 8'h04);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk({15'h0000, bottom}, 16'h0001);
    rc16(ADDR_COUNTER_LOW, 16'h0000);
    results();
  end
endmodule
